/* File: rtl/cbx_pkg.sv */
package cbx_pkg;

   // ------------------------------------------------------------
   // apb map
   // ------------------------------------------------------------
   localparam logic [11:0] ADDR_CMD     = 12'h000;
   localparam logic [11:0] ADDR_FLAGS   = 12'h004;
   localparam logic [11:0] ADDR_PC      = 12'h008;
   localparam logic [11:0] ADDR_STAT    = 12'h00C;
   localparam logic [11:0] ADDR_RF_BASE = 12'h100;
   localparam logic [11:0] ADDR_RF_LAST = 12'h17C;

   // ------------------------------------------------------------
   // command word and status word fields
   // ------------------------------------------------------------
   localparam int CMD_OP_LSB  = 24;
   localparam int CMD_D_LSB   = 16;
   localparam int CMD_R_LSB   = 8;
   localparam int CMD_IMM_LSB = 0;
   localparam int STAT_BUSY   = 0;
   localparam int STAT_OP_LSB = 8;

   // ------------------------------------------------------------
   // status register bits
   // ------------------------------------------------------------
   localparam int SR_C = 0;
   localparam int SR_Z = 1;
   localparam int SR_N = 2;
   localparam int SR_V = 3;
   localparam int SR_T = 6;
   localparam int SR_I = 7;
   localparam logic [7:0]  FLAGS_RST = 8'h00;
   localparam logic [15:0] PC_RST    = 16'h0000;

   // ------------------------------------------------------------
   // pointer registers
   // ------------------------------------------------------------
   localparam logic [4:0] X_LO = 5'h1A;
   localparam logic [4:0] X_HI = 5'h1B;
   localparam logic [4:0] Y_LO = 5'h1C;
   localparam logic [4:0] Y_HI = 5'h1D;

   // ------------------------------------------------------------
   // operation codes; 0x10..0x1F: named flag ops, 2*bit raise, +1 lower
   // ------------------------------------------------------------
   localparam logic [5:0] OP_NOP       = 6'h00;
   localparam logic [5:0] OP_BR_IE     = 6'h01;
   localparam logic [5:0] OP_BR_ID     = 6'h02;
   localparam logic [5:0] OP_IO_RAISE  = 6'h03;
   localparam logic [5:0] OP_IO_LOWER  = 6'h04;
   localparam logic [5:0] OP_SHL_ZERO  = 6'h05;
   localparam logic [5:0] OP_SHR_ZERO  = 6'h06;
   localparam logic [5:0] OP_ROT_UP    = 6'h07;
   localparam logic [5:0] OP_ROT_DOWN  = 6'h08;
   localparam logic [5:0] OP_SHR_SIGN  = 6'h09;
   localparam logic [5:0] OP_SWAP      = 6'h0A;
   localparam logic [5:0] OP_IDX_RAISE = 6'h0B;
   localparam logic [5:0] OP_IDX_LOWER = 6'h0C;
   localparam logic [5:0] OP_BIT_TO_T  = 6'h0D;
   localparam logic [5:0] OP_T_TO_BIT  = 6'h0E;
   localparam logic [1:0] OP_FLAG_GRP  = 2'h1;
   localparam logic [5:0] OP_MOVE      = 6'h20;
   localparam logic [5:0] OP_PAIR_COPY = 6'h21;
   localparam logic [5:0] OP_IMM_LOAD  = 6'h22;
   localparam logic [5:0] OP_LD_X      = 6'h23;
   localparam logic [5:0] OP_LD_X_INC  = 6'h24;
   localparam logic [5:0] OP_LD_X_DEC  = 6'h25;
   localparam logic [5:0] OP_LD_Y      = 6'h26;
   localparam logic [5:0] OP_LD_Y_INC  = 6'h27;

   typedef enum logic [2:0] {
      CBX_IDLE = 3'b001,
      CBX_EX1  = 3'b010,
      CBX_EX2  = 3'b100
   } cbx_state_e;

endpackage

/* File: rtl/cbx_exec.sv */
`timescale 1ns/1ps
module cbx_exec #(
   parameter int PC_W = 16
)(
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rstn,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // io space
   output logic      [4:0]        io_addr,
   output logic                   io_rd,
   input  wire logic [7:0]        io_rdata,
   output logic                   io_wr,
   output logic      [7:0]        io_wdata,
   // data memory
   output logic      [15:0]       dm_addr,
   output logic                   dm_rd,
   input  wire logic [7:0]        dm_rdata,
   // status
   output logic                   busy,
   output logic      [PC_W-1:0]   pc
);
   import cbx_pkg::*;

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   function automatic logic addr_mapped(input logic [11:0] a);
      addr_mapped = (a == ADDR_CMD) || (a == ADDR_FLAGS) || (a == ADDR_PC) || (a == ADDR_STAT) ||
                    (a >= ADDR_RF_BASE && a <= ADDR_RF_LAST && a[1:0] == 2'h0);
   endfunction

   // returns {hit, raise, index}
   function automatic logic [4:0] flag_op(input logic [5:0] op, input logic [2:0] s);
      flag_op = 5'h00;
      if (op[5:4] == OP_FLAG_GRP) begin
         flag_op = {1'b1, ~op[0], op[3:1]};
      end else if (op == OP_IDX_RAISE) begin
         flag_op = {2'b11, s};
      end else if (op == OP_IDX_LOWER) begin
         flag_op = {2'b10, s};
      end
   endfunction

   // returns {hit, carry out, result}
   function automatic logic [9:0] shift_op(input logic [5:0] op, input logic [7:0] v, input logic c);
      case (op)
         OP_SHL_ZERO: shift_op = {1'b1, v[7], v[6:0], 1'b0};
         OP_SHR_ZERO: shift_op = {1'b1, v[0], 1'b0, v[7:1]};
         OP_ROT_UP:   shift_op = {1'b1, v[7], v[6:0], c};
         OP_ROT_DOWN: shift_op = {1'b1, v[0], c, v[7:1]};
         OP_SHR_SIGN: shift_op = {1'b1, v[0], v[7], v[7:1]};
         default:     shift_op = 10'h000;
      endcase
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   cbx_state_e  state;
   cbx_state_e  next_state;
   logic [7:0]  rf [32];
   logic [7:0]  flags;
   logic [5:0]  cmd_op;
   logic [4:0]  cmd_d;
   logic [4:0]  cmd_r;
   logic [7:0]  cmd_imm;

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   logic apb_acc;
   logic apb_wr;
   logic cmd_start;
   logic [4:0] apb_rf_idx;

   assign busy       = (state != CBX_IDLE);
   assign apb_acc    = psel & penable;
   assign pready     = ~(pwrite & busy);
   assign pslverr    = apb_acc & ~addr_mapped(paddr);
   assign apb_wr     = apb_acc & pwrite & pready & addr_mapped(paddr);
   assign cmd_start  = apb_wr & (paddr == ADDR_CMD);
   assign apb_rf_idx = paddr[6:2];

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (psel & ~penable & ~pwrite) begin
         prdata <= 32'h0000_0000;
         if (paddr == ADDR_FLAGS) begin
            prdata[7:0] <= flags;
         end else if (paddr == ADDR_PC) begin
            prdata[PC_W-1:0] <= pc;
         end else if (paddr == ADDR_STAT) begin
            prdata[STAT_BUSY]               <= busy;
            prdata[STAT_OP_LSB +: 6]        <= cmd_op;
         end else if (addr_mapped(paddr) && paddr >= ADDR_RF_BASE) begin
            prdata[7:0] <= rf[apb_rf_idx];
         end
      end
   end

   // ------------------------------------------------------------
   // command latch
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_op  <= OP_NOP;
         cmd_d   <= 5'h00;
         cmd_r   <= 5'h00;
         cmd_imm <= 8'h00;
      end else if (cmd_start) begin
         cmd_op  <= pwdata[CMD_OP_LSB +: 6];
         cmd_d   <= pwdata[CMD_D_LSB +: 5];
         cmd_r   <= pwdata[CMD_R_LSB +: 5];
         cmd_imm <= pwdata[CMD_IMM_LSB +: 8];
      end
   end

   // ------------------------------------------------------------
   // execution
   // ------------------------------------------------------------
   logic [15:0]     ptr;
   logic [15:0]     ptr_new;
   logic [7:0]      mask;
   logic [4:0]      fop;
   logic [9:0]      sop;
   logic            rf_we0;
   logic [4:0]      rf_a0;
   logic [7:0]      rf_d0;
   logic            rf_we1;
   logic [4:0]      rf_a1;
   logic [7:0]      rf_d1;
   logic [7:0]      next_flags;
   logic [PC_W-1:0] next_pc;
   logic            next_io_rd;
   logic            next_io_wr;
   logic [7:0]      next_io_wdata;
   logic            next_dm_rd;
   logic [15:0]     next_dm_addr;

   always_comb begin
      next_state    = state;
      next_flags    = flags;
      next_pc       = pc;
      rf_we0        = 1'b0;
      rf_a0         = cmd_d;
      rf_d0         = 8'h00;
      rf_we1        = 1'b0;
      rf_a1         = cmd_d;
      rf_d1         = 8'h00;
      next_io_rd    = 1'b0;
      next_io_wr    = 1'b0;
      next_io_wdata = io_wdata;
      next_dm_rd    = 1'b0;
      next_dm_addr  = dm_addr;
      mask          = 8'h01 << cmd_imm[2:0];
      fop           = flag_op(cmd_op, cmd_imm[2:0]);
      sop           = shift_op(cmd_op, rf[cmd_d], flags[SR_C]);
      if (cmd_op == OP_LD_Y || cmd_op == OP_LD_Y_INC) begin
         ptr = {rf[Y_HI], rf[Y_LO]};
      end else begin
         ptr = {rf[X_HI], rf[X_LO]};
      end
      ptr_new = (cmd_op == OP_LD_X_DEC) ? ptr - 16'h0001 : ptr + 16'h0001;
      case (state)
         CBX_IDLE: begin
            if (cmd_start) begin
               next_state = CBX_EX1;
            end
         end
         CBX_EX1: begin
            next_state = CBX_IDLE;
            next_pc    = pc + {{(PC_W-1){1'b0}}, 1'b1};
            if (fop[4]) begin
               next_flags[fop[2:0]] = fop[3];
            end else if (sop[9]) begin
               rf_we0           = 1'b1;
               rf_d0            = sop[7:0];
               next_flags[SR_C] = sop[8];
               next_flags[SR_Z] = (sop[7:0] == 8'h00);
               next_flags[SR_N] = sop[7];
               next_flags[SR_V] = sop[7] ^ sop[8];
            end else begin
               case (cmd_op)
                  OP_BR_IE, OP_BR_ID: begin
                     if (flags[SR_I] == (cmd_op == OP_BR_IE)) begin
                        next_pc    = pc + {{(PC_W-7){cmd_imm[6]}}, cmd_imm[6:0]} + {{(PC_W-1){1'b0}}, 1'b1};
                        next_state = CBX_EX2;
                     end
                  end
                  OP_IO_RAISE, OP_IO_LOWER: begin
                     next_io_rd = 1'b1;
                     next_state = CBX_EX2;
                  end
                  OP_SWAP: begin
                     rf_we0 = 1'b1;
                     rf_d0  = {rf[cmd_d][3:0], rf[cmd_d][7:4]};
                  end
                  OP_BIT_TO_T: begin
                     next_flags[SR_T] = |(rf[cmd_r] & mask);
                  end
                  OP_T_TO_BIT: begin
                     rf_we0 = 1'b1;
                     rf_d0  = flags[SR_T] ? (rf[cmd_d] | mask) : (rf[cmd_d] & ~mask);
                  end
                  OP_MOVE: begin
                     rf_we0 = 1'b1;
                     rf_d0  = rf[cmd_r];
                  end
                  OP_PAIR_COPY: begin
                     rf_we0 = 1'b1;
                     rf_a0  = {cmd_d[4:1], 1'b0};
                     rf_d0  = rf[{cmd_r[4:1], 1'b0}];
                     rf_we1 = 1'b1;
                     rf_a1  = {cmd_d[4:1], 1'b1};
                     rf_d1  = rf[{cmd_r[4:1], 1'b1}];
                  end
                  OP_IMM_LOAD: begin
                     rf_we0 = 1'b1;
                     rf_d0  = cmd_imm;
                  end
                  OP_LD_X, OP_LD_Y, OP_LD_X_INC, OP_LD_Y_INC, OP_LD_X_DEC: begin
                     next_dm_rd   = 1'b1;
                     next_dm_addr = (cmd_op == OP_LD_X_DEC) ? ptr_new : ptr;
                     next_state   = CBX_EX2;
                     if (cmd_op != OP_LD_X && cmd_op != OP_LD_Y) begin
                        rf_we0 = 1'b1;
                        rf_a0  = (cmd_op == OP_LD_Y_INC) ? Y_LO : X_LO;
                        rf_d0  = ptr_new[7:0];
                        rf_we1 = 1'b1;
                        rf_a1  = (cmd_op == OP_LD_Y_INC) ? Y_HI : X_HI;
                        rf_d1  = ptr_new[15:8];
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
         CBX_EX2: begin
            next_state = CBX_IDLE;
            if (cmd_op == OP_IO_RAISE) begin
               next_io_wr    = 1'b1;
               next_io_wdata = io_rdata | mask;
            end else if (cmd_op == OP_IO_LOWER) begin
               next_io_wr    = 1'b1;
               next_io_wdata = io_rdata & ~mask;
            end else if (cmd_op != OP_BR_IE && cmd_op != OP_BR_ID) begin
               rf_we0 = 1'b1;
               rf_a0  = cmd_d;
               rf_d0  = dm_rdata;
            end
         end
         default: begin
            next_state = CBX_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= CBX_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ------------------------------------------------------------
   // register file
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 32; i++) begin
            rf[i] <= 8'h00;
         end
      end else if (apb_wr && paddr >= ADDR_RF_BASE) begin
         rf[apb_rf_idx] <= pwdata[7:0];
      end else begin
         if (rf_we0) begin
            rf[rf_a0] <= rf_d0;
         end
         if (rf_we1) begin
            rf[rf_a1] <= rf_d1;
         end
      end
   end

   // ------------------------------------------------------------
   // status register and program counter
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         flags <= FLAGS_RST;
      end else if (apb_wr && paddr == ADDR_FLAGS) begin
         flags <= pwdata[7:0];
      end else begin
         flags <= next_flags;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pc <= PC_RST[PC_W-1:0];
      end else if (apb_wr && paddr == ADDR_PC) begin
         pc <= pwdata[PC_W-1:0];
      end else begin
         pc <= next_pc;
      end
   end

   // ------------------------------------------------------------
   // memory and io strobes
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         io_addr  <= 5'h00;
         io_rd    <= 1'b0;
         io_wr    <= 1'b0;
         io_wdata <= 8'h00;
         dm_addr  <= 16'h0000;
         dm_rd    <= 1'b0;
      end else begin
         if (next_io_rd) begin
            io_addr <= cmd_d;
         end
         io_rd    <= next_io_rd;
         io_wr    <= next_io_wr;
         io_wdata <= next_io_wdata;
         dm_addr  <= next_dm_addr;
         dm_rd    <= next_dm_rd;
      end
   end

endmodule

/* File: verification/cbx_exec_monitor.sv */
`timescale 1ns/1ps
module cbx_exec_monitor #(
   parameter int PC_W = 16
)(
   input wire logic            sys_clk,
   input wire logic            rstn,
   input wire logic            psel,
   input wire logic            penable,
   input wire logic            pwrite,
   input wire logic [11:0]     paddr,
   input wire logic [31:0]     pwdata,
   input wire logic [31:0]     prdata,
   input wire logic            pready,
   input wire logic            pslverr,
   input wire logic [4:0]      io_addr,
   input wire logic            io_rd,
   input wire logic [7:0]      io_rdata,
   input wire logic            io_wr,
   input wire logic [7:0]      io_wdata,
   input wire logic [15:0]     dm_addr,
   input wire logic            dm_rd,
   input wire logic [7:0]      dm_rdata,
   input wire logic            busy,
   input wire logic [PC_W-1:0] pc
);
   import cbx_pkg::*;
   // ------------------------------------------------------------
   // command timing checks
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   wire wr_done = psel && penable && pready && pwrite;
   wire cmd_go  = wr_done && paddr == ADDR_CMD;
   stall_cause_a: assert property (psel && penable && !pready |-> pwrite && busy)
      else $error("pready low outside a busy write");
   cmd_start_a: assert property (cmd_go |=> busy)
      else $error("command did not start");
   busy_len_a: assert property ($rose(busy) |-> ##[1:2] !busy)
      else $error("busy longer than two cycles");
   busy_cause_a: assert property ($rose(busy) |-> $past(cmd_go))
      else $error("busy without command");
   io_seq_a: assert property (io_rd |-> busy ##1 (io_wr && !busy && $stable(io_addr)))
      else $error("io write does not follow io read");
   io_bit_a: assert property (io_wr |-> $countones(io_wdata ^ $past(io_rdata)) <= 1)
      else $error("io write alters more than one bit");
   ld_read_a: assert property (dm_rd |-> $past(busy) && busy ##1 !busy)
      else $error("memory read outside second cycle");
   pc_hold_a: assert property (!$stable(pc) |-> $past(busy) || $past(wr_done))
      else $error("pc moved while idle");
   cover property (io_wr);
   cover property (dm_rd);
   cover property (busy ##1 busy);
endmodule
bind cbx_exec cbx_exec_monitor #(.PC_W(PC_W)) cbx_exec_monitor_inst (
   .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .io_addr(io_addr), .io_rd(io_rd),
   .io_rdata(io_rdata), .io_wr(io_wr), .io_wdata(io_wdata), .dm_addr(dm_addr), .dm_rd(dm_rd),
   .dm_rdata(dm_rdata), .busy(busy), .pc(pc)
);

/* File: verification/test_cbx_exec.sv */
`timescale 1ns/1ps
module test_cbx_exec;
   import cbx_pkg::*;
   logic        sys_clk;
   logic        rstn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [4:0]  io_addr;
   logic        io_rd;
   logic [7:0]  io_rdata;
   logic        io_wr;
   logic [7:0]  io_wdata;
   logic [15:0] dm_addr;
   logic        dm_rd;
   logic [7:0]  dm_rdata;
   logic        busy;
   logic [15:0] pc;
   logic [7:0]  io_mem [32];
   logic [31:0] rd;
   logic        err;
   logic [2:0]  bb;
   int          n_mismatch;
   int          cmp_count;
   int          cyc;
   cbx_exec #(.PC_W(16)) cbx_exec_inst (
      .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .io_addr(io_addr), .io_rd(io_rd),
      .io_rdata(io_rdata), .io_wr(io_wr), .io_wdata(io_wdata), .dm_addr(dm_addr), .dm_rd(dm_rd),
      .dm_rdata(dm_rdata), .busy(busy), .pc(pc)
   );
   // ------------------------------------------------------------
   // io space and data memory answers
   // ------------------------------------------------------------
   function automatic logic [7:0] dmf(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5A;
   endfunction
   assign io_rdata = io_rd ? io_mem[io_addr] : ~io_mem[io_addr];
   assign dm_rdata = dm_rd ? dmf(dm_addr) : ~dmf(dm_addr);
   always @(posedge sys_clk) begin
      if (io_wr)
         io_mem[io_addr] <= io_wdata;
   end
   // ------------------------------------------------------------
   // bus tasks
   // ------------------------------------------------------------
   function automatic logic [11:0] ra(input logic [4:0] n);
      return ADDR_RF_BASE + {5'h0, n, 2'h0};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int   n;
      logic ok;
      @(posedge sys_clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      ok = 1'b0;
      for (n = 0; n < 20 && !ok; n++) begin
         @(posedge sys_clk);
         ok  = (pready === 1'b1);
         rd  = prdata;
         err = pslverr;
      end
      psel    <= 1'b0;
      penable <= 1'b0;
      if (!ok) begin
         n_mismatch++;
         finish_test();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask
   task automatic run(input logic [5:0] op, input logic [4:0] d, input logic [4:0] r, input logic [7:0] imm);
      int n;
      apb(1'b1, ADDR_CMD, {2'h0, op, 3'h0, d, 3'h0, r, imm});
      cyc = 0;
      for (n = 0; n < 20; n++) begin
         @(negedge sys_clk);
         if (busy !== 1'b1)
            break;
         cyc++;
      end
      if (n == 20) begin
         n_mismatch++;
         finish_test();
      end
   endtask
   task automatic shchk(input logic [5:0] op, input logic [7:0] v, input logic [7:0] res, input logic [7:0] sr);
      wr(ra(5'd4), {24'h0, v});
      wr(ADDR_FLAGS, 32'h71);
      run(op, 5'd4, 5'h0, 8'h00);
      check(cyc, 32'd1);
      rdchk(ra(5'd4), {24'h0, res});
      rdchk(ADDR_FLAGS, {24'h0, sr});
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   initial begin
      #400000;
      n_mismatch++;
      finish_test();
   end
   initial begin
      rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
      n_mismatch = 0; cmp_count = 0;
      for (int i = 0; i < 32; i++)
         io_mem[i] = 8'h00;
      io_mem[5] = 8'hA5;
      repeat (8) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rdchk(ADDR_FLAGS, 32'h0);
      rdchk(ADDR_PC, 32'h0);
      rdchk(ra(5'd3), 32'h0);
      rdchk(12'h010, 32'h0);
      check(err, 32'h1);
      for (int b = 0; b < 8; b++) begin
         bb = b[2:0];
         run({OP_FLAG_GRP, bb, 1'b0}, 5'h0, 5'h0, 8'h00);
         check(cyc, 32'd1);
         rdchk(ADDR_FLAGS, 32'h1 << b);
         run(OP_IDX_LOWER, 5'h0, 5'h0, {5'h0, bb});
         rdchk(ADDR_FLAGS, 32'h0);
         run(OP_IDX_RAISE, 5'h0, 5'h0, {5'h0, bb});
         rdchk(ADDR_FLAGS, 32'h1 << b);
         run({OP_FLAG_GRP, bb, 1'b1}, 5'h0, 5'h0, 8'h00);
         rdchk(ADDR_FLAGS, 32'h0);
      end
      wr(ADDR_FLAGS, 32'h80);
      wr(ADDR_PC, 32'h10);
      run(OP_BR_IE, 5'h0, 5'h0, 8'h05);
      check(cyc, 32'd2);
      rdchk(ADDR_PC, 32'h16);
      run(OP_BR_ID, 5'h0, 5'h0, 8'h7D);
      check(cyc, 32'd1);
      rdchk(ADDR_PC, 32'h17);
      wr(ADDR_FLAGS, 32'h0);
      run(OP_BR_ID, 5'h0, 5'h0, 8'h7D);
      check(cyc, 32'd2);
      rdchk(ADDR_PC, 32'h15);
      run(OP_BR_IE, 5'h0, 5'h0, 8'h05);
      rdchk(ADDR_PC, 32'h16);
      rdchk(ADDR_FLAGS, 32'h0);
      shchk(OP_SHL_ZERO, 8'h96, 8'h2C, 8'h79);
      shchk(OP_SHL_ZERO, 8'h80, 8'h00, 8'h7B);
      shchk(OP_SHR_ZERO, 8'h96, 8'h4B, 8'h70);
      shchk(OP_ROT_UP, 8'h96, 8'h2D, 8'h79);
      shchk(OP_ROT_DOWN, 8'h17, 8'h8B, 8'h75);
      shchk(OP_SHR_SIGN, 8'h96, 8'hCB, 8'h7C);
      shchk(OP_SWAP, 8'h96, 8'h69, 8'h71);
      wr(ra(5'd7), 32'h08);
      wr(ADDR_FLAGS, 32'h41);
      run(OP_BIT_TO_T, 5'h0, 5'd7, 8'h02);
      rdchk(ADDR_FLAGS, 32'h01);
      run(OP_BIT_TO_T, 5'h0, 5'd7, 8'h03);
      check(cyc, 32'd1);
      rdchk(ADDR_FLAGS, 32'h41);
      wr(ra(5'd9), 32'h81);
      run(OP_T_TO_BIT, 5'd9, 5'h0, 8'h05);
      check(cyc, 32'd1);
      rdchk(ra(5'd9), 32'hA1);
      run(OP_IO_RAISE, 5'd5, 5'h0, 8'h01);
      check(cyc, 32'd2);
      run(OP_IO_LOWER, 5'd5, 5'h0, 8'h07);
      check(cyc, 32'd2);
      rdchk(ADDR_FLAGS, 32'h41);
      check(io_mem[5], 32'h27);
      wr(ra(5'd2), 32'h11);
      wr(ra(5'd3), 32'h22);
      run(OP_MOVE, 5'd10, 5'd2, 8'h00);
      check(cyc, 32'd1);
      run(OP_PAIR_COPY, 5'd13, 5'd3, 8'h00);
      check(cyc, 32'd1);
      run(OP_IMM_LOAD, 5'd16, 5'h0, 8'hC3);
      run(6'h3F, 5'h0, 5'h0, 8'h00);
      rdchk(ADDR_PC, 32'h26);
      rdchk(ra(5'd10), 32'h11);
      rdchk(ra(5'd12), 32'h11);
      rdchk(ra(5'd13), 32'h22);
      rdchk(ra(5'd16), 32'hC3);
      wr(ra(X_LO), 32'h00);
      wr(ra(X_HI), 32'h02);
      wr(ra(Y_LO), 32'h33);
      wr(ra(Y_HI), 32'h00);
      run(OP_LD_X_DEC, 5'd1, 5'h0, 8'h00);
      check(cyc, 32'd2);
      run(OP_LD_X_INC, 5'd2, 5'h0, 8'h00);
      check(cyc, 32'd2);
      run(OP_LD_X, 5'd3, 5'h0, 8'h00);
      run(OP_LD_Y_INC, 5'd4, 5'h0, 8'h00);
      run(OP_LD_Y, 5'd5, 5'h0, 8'h00);
      rdchk(ra(5'd1), 32'hA4);
      rdchk(ra(5'd2), 32'hA4);
      rdchk(ra(5'd3), 32'h58);
      rdchk(ra(5'd4), 32'h69);
      rdchk(ra(5'd5), 32'h6E);
      rdchk(ra(X_HI), 32'h02);
      rdchk(ra(Y_LO), 32'h34);
      rdchk(ADDR_FLAGS, 32'h41);
      rdchk(ADDR_STAT, 32'h0000_2600);
      finish_test();
   end
endmodule
